// *** pmcc_pkg.sv ***
// constants for the phase and mutual current compensation block
// Notes on behaviour
// RULE1 - voltage and current leave together, no skew
// RULE2 - each phase has own 4-bit fine trim
// RULE3 - subtract scaled integrated voltage from voltage
// RULE4 - base coefficient from coarse and fine trim
// RULE5 - precision or sensor bit widens coefficient
// RULE6 - extension bits come from mutual byte a
// RULE7 - compensation tick divider from mode bits
// RULE8 - mutual correction only with sensor bit clear
// RULE9 - mutual correction only with precision mode clear
// RULE10 - single-phase alpha from byte a, sign bit 8
// RULE11 - beta from byte b; cross-subtract s, t
// RULE12 - coefficients follow configuration without reset
package pmcc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TRIM = 8'h04;
   localparam logic [7:0] ADDR_MUTUAL = 8'h08;
   localparam logic [7:0] ADDR_COEF = 8'h0C;
   // control field positions
   localparam int CTRL_PM = 0;
   localparam int CTRL_TCS = 1;
   localparam int CTRL_HSA = 2;
   localparam int CTRL_CLOCK_DIVIDER_SELECT = 3;
   localparam int CTRL_COARSE = 4;
   localparam int CTRL_TOPO = 8;
   // trim field positions
   localparam int TRIM_R = 0;
   localparam int TRIM_S = 4;
   localparam int TRIM_T = 8;
   // mutual register field positions
   localparam int MUT_A = 0;
   localparam int MUT_B = 16;
   localparam int EXT_LSB = 0;
   localparam int SIGN_BIT = 8;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TRIM_RST = 32'h0000_0000;
   localparam logic [31:0] MUTUAL_RST = 32'h0000_0000;
   // tick divider reloads (divide ratio minus one)
   localparam logic [2:0] DIV2_RELOAD = 3'h1;
   localparam logic [2:0] DIV4_RELOAD = 3'h3;
   localparam logic [2:0] DIV8_RELOAD = 3'h7;
   // topology values above this are single-phase
   localparam logic [2:0] TOPO_MULTI_MAX = 3'h3;
   // scaling: mutual factors are over 8192, voltage vector shift
   localparam int MUT_SHIFT = 13;
   localparam int VOLT_SHIFT = 6;
   // stream sizes
   localparam int SAMPLE_W = 16;
   localparam int WORD_W = 2 + 4 * SAMPLE_W;
   localparam int FIFO_DEPTH = 16;
endpackage

// *** pmcc_src_model.sv ***
// sample source standing in for the modulator front-end
`timescale 1ns/100ps
module pmcc_src_model (
   input wire logic ref_clk,
   input wire logic in_ready,
   output logic in_valid,
   output logic [1:0] in_phase,
   output logic [15:0] in_volt,
   output logic [15:0] in_integ,
   output logic [15:0] in_cur_s,
   output logic [15:0] in_cur_t
);
   // idle lines start low
   initial begin
      in_valid = 1'b0;
      {in_phase, in_volt, in_integ, in_cur_s, in_cur_t} = '0;
   end
   // offer a word after gap idle cycles, hold it until taken
   task automatic send(input logic [65:0] w, input int gap, input bit last, output int n);
      n = 0;
      repeat (gap) @(posedge ref_clk);
      in_valid <= 1'b1;
      {in_phase, in_volt, in_integ, in_cur_s, in_cur_t} <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (in_ready !== 1'b1 && n < 400);
      // released lines show garbage, not the old word
      if (last) begin
         in_valid <= 1'b0;
         {in_phase, in_volt, in_integ, in_cur_s, in_cur_t} <= ~w;
      end
   endtask
endmodule // pmcc_src_model

// *** pmcc_top.sv ***
// fifo, coefficient slice and top of the phase and mutual compensation block
`timescale 1ns/100ps
// first-word-through buffer between the sample source and the compensation stage
// both flags are registered from the next count, so in_ready drops in the same
// cycle the sixteenth word lands; a source that keeps in_valid up simply waits
// the storage array has no reset, only the pointers, the count and the two flags do
// out_data is read straight from the array at the read index, so it is valid
// whenever out_valid is high, with no extra read latency
module pmcc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW-1:0] wr_ptr;  // write index
   logic [AW-1:0] rd_ptr;  // read index
   logic [CW-1:0] count;  // words held
   logic [CW-1:0] next_count;
   // handshakes that move a word in or out
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign next_count = count + CW'(push) - CW'(pop);
   assign out_data = mem[rd_ptr];
   // pointers wrap naturally because the depth is a power of two
   // flags look at next_count so they never lag the storage by a cycle
   // pointers, count and registered flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
         rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
         count <= next_count;
         in_ready <= next_count != FULL_CNT;
         out_valid <= next_count != '0;
      end
   end
   // the array is written only on an accepted word, never cleared
   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // pmcc_fifo

// one coefficient slice, used once per phase
// the magnitude is at most 127 in wide mode, so eight signed bits always hold
// the result: 64 - 127 = -63 on the positive branch and -127 on the negative one
// the coefficient is registered so a configuration write settles in one cycle
// and every sample popped after that cycle sees the new value
module pmcc_coef (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] fine,
   input wire logic [1:0] coarse,
   input wire logic [1:0] ext,
   input wire logic ext_mode,
   output logic signed [7:0] coef
);
   wire [6:0] sum = ext_mode ? {ext, coarse[0], fine} : {2'b00, coarse[0], fine};  // magnitude part
   wire signed [7:0] pos_ext = 8'sh40 - $signed({1'b0, sum});  // 64 minus sum
   wire signed [7:0] pos_base = 8'sh10 - $signed({4'h0, fine});  // 16 minus fine
   wire signed [7:0] neg = -$signed({1'b0, sum});  // negated sum
   wire signed [7:0] next_coef = coarse[1] ? (ext_mode ? pos_ext : pos_base) : neg;
   // both positive branches are built and the mode picks one; the base
   // branch ignores the extension and coarse bit 0
   // RULE4 RULE5 RULE12 coefficient recomputed each cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         coef <= 8'sh00;
      end else begin
         coef <= next_coef;
      end
   end
endmodule // pmcc_coef

// top: register file, per-phase coefficient slices, compensation tick divider,
// sample buffer and the registered output stage
// the bus answers every request, mapped or not, one cycle after it is taken;
// the ack is fed back into the decode so a held strobe is never acked in two back-to-back cycles
// the sample word carries its phase with it, so the coefficient is picked per
// word and a phase without a slice (code 3) passes with a zero coefficient
module pmcc_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [1:0] in_phase,
   input wire logic [15:0] in_volt,
   input wire logic [15:0] in_integ,
   input wire logic [15:0] in_cur_s,
   input wire logic [15:0] in_cur_t,
   output logic out_valid,
   output logic [1:0] out_phase,
   output logic [15:0] out_volt,
   output logic [15:0] out_cur_s,
   output logic [15:0] out_cur_t,
   output logic phc_tick
);
   logic [31:0] ctrl;  // mode bits, coarse trim, topology
   logic [31:0] trim;  // per-phase fine trims
   logic [31:0] mutual;  // mutual bytes a and b
   logic [2:0] div_cnt;  // tick divider
   logic mutual_active;  // cross-correction enabled
   logic signed [7:0] coef_r;
   logic signed [7:0] coef_s;
   logic signed [7:0] coef_t;
   logic fifo_valid;
   logic [pmcc_pkg::WORD_W-1:0] fifo_data;

   // bus decode
   // a request counts only while no ack is out, which keeps the classic cycle
   // to exactly one ack per strobe
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i;
   wire sel_ctrl = wb_adr_i == pmcc_pkg::ADDR_CTRL;
   wire sel_trim = wb_adr_i == pmcc_pkg::ADDR_TRIM;
   wire sel_mut = wb_adr_i == pmcc_pkg::ADDR_MUTUAL;
   wire sel_coef = wb_adr_i == pmcc_pkg::ADDR_COEF;
   wire [31:0] mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] next_ctrl = (ctrl & ~mask) | (wb_dat_i & mask);
   wire [31:0] next_trim = (trim & ~mask) | (wb_dat_i & mask);
   wire [31:0] next_mutual = (mutual & ~mask) | (wb_dat_i & mask);
   wire [31:0] coef_word = {mutual_active, 7'h00, coef_t, coef_s, coef_r};  // live state
   // unmapped offsets read as zero
   wire [31:0] next_rdata = sel_ctrl ? ctrl : sel_trim ? trim : sel_mut ? mutual : sel_coef ? coef_word : 32'h0;

   // every field is a plain slice of a register; positions are in the package
   // named configuration fields
   wire precision_mode = ctrl[pmcc_pkg::CTRL_PM];
   wire current_sensor_select = ctrl[pmcc_pkg::CTRL_TCS];
   wire fast_clock_select = ctrl[pmcc_pkg::CTRL_HSA];
   wire clock_divider_select = ctrl[pmcc_pkg::CTRL_CLOCK_DIVIDER_SELECT];
   wire [1:0] phase_coarse_trim = ctrl[pmcc_pkg::CTRL_COARSE +: 2];
   wire [2:0] line_topology = ctrl[pmcc_pkg::CTRL_TOPO +: 3];
   wire [3:0] phase_trim_r = trim[pmcc_pkg::TRIM_R +: 4];
   wire [3:0] phase_trim_s = trim[pmcc_pkg::TRIM_S +: 4];
   wire [3:0] phase_trim_t = trim[pmcc_pkg::TRIM_T +: 4];
   wire [8:0] mutual_comp_byte_a = mutual[pmcc_pkg::MUT_A +: 9];
   wire [7:0] mutual_comp_byte_b = mutual[pmcc_pkg::MUT_B +: 8];
   // RULE6 extension taken from byte a
   wire [1:0] phase_ext_trim = mutual_comp_byte_a[pmcc_pkg::EXT_LSB +: 2];
   // RULE5 wide mode under precision or sensor bit
   wire ext_mode = precision_mode || current_sensor_select;
   // RULE8 RULE9 RULE10 gating of mutual correction
   wire next_mutual_active = !current_sensor_select && !precision_mode
      && (line_topology > pmcc_pkg::TOPO_MULTI_MAX);

   // byte lanes are merged per lane, reserved bits are stored and read back
   // read data is held until the next read so a slow master still finds it
   // register writes and registered read answer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= pmcc_pkg::CTRL_RST;
         trim <= pmcc_pkg::TRIM_RST;
         mutual <= pmcc_pkg::MUTUAL_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ctrl <= (bus_wr && sel_ctrl) ? next_ctrl : ctrl;
         trim <= (bus_wr && sel_trim) ? next_trim : trim;
         mutual <= (bus_wr && sel_mut) ? next_mutual : mutual;
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i) ? next_rdata : wb_dat_o;
      end
   end

   // the three slices share coarse and extension bits and differ in fine trim
   // RULE2 one trim slice per phase
   pmcc_coef u_coef_r (.ref_clk(ref_clk), .rst_n(rst_n), .fine(phase_trim_r), .coarse(phase_coarse_trim),
      .ext(phase_ext_trim), .ext_mode(ext_mode), .coef(coef_r));
   pmcc_coef u_coef_s (.ref_clk(ref_clk), .rst_n(rst_n), .fine(phase_trim_s), .coarse(phase_coarse_trim),
      .ext(phase_ext_trim), .ext_mode(ext_mode), .coef(coef_s));
   pmcc_coef u_coef_t (.ref_clk(ref_clk), .rst_n(rst_n), .fine(phase_trim_t), .coarse(phase_coarse_trim),
      .ext(phase_ext_trim), .ext_mode(ext_mode), .coef(coef_t));

   // the divider reloads only when it reaches zero, so a new ratio takes
   // effect after the count in progress; no short tick is ever produced
   // RULE7 divider reload from mode bits
   wire [2:0] reload = precision_mode
      ? (clock_divider_select ? pmcc_pkg::DIV4_RELOAD : pmcc_pkg::DIV2_RELOAD)
      : (fast_clock_select ? pmcc_pkg::DIV4_RELOAD : pmcc_pkg::DIV8_RELOAD);
   wire div_zero = div_cnt == 3'h0;

   // the counter starts at zero so the first tick follows reset release at
   // once; the correction enable is registered here as well
   // compensation tick generator
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 3'h0;
         phc_tick <= 1'b0;
         mutual_active <= 1'b0;
      end else begin
         div_cnt <= div_zero ? reload : div_cnt - 3'h1;
         phc_tick <= div_zero;
         mutual_active <= next_mutual_active;
      end
   end

   // the tick is the pop strobe, so words leave at the compensation rate
   // and a full buffer pushes back on the source through in_ready
   // sample buffer, drained one word per compensation tick
   pmcc_fifo #(.WIDTH(pmcc_pkg::WORD_W), .DEPTH(pmcc_pkg::FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
      .in_data({in_phase, in_volt, in_integ, in_cur_s, in_cur_t}),
      .out_valid(fifo_valid), .out_ready(phc_tick), .out_data(fifo_data));

   // field order in the word: phase, voltage, integrated voltage, S, T
   // unpack popped word
   wire pop = fifo_valid && phc_tick;
   wire [1:0] f_phase = fifo_data[64 +: 2];
   wire signed [15:0] f_volt = fifo_data[48 +: 16];
   wire signed [15:0] f_integ = fifo_data[32 +: 16];
   wire signed [15:0] f_cur_s = fifo_data[16 +: 16];
   wire signed [15:0] f_cur_t = fifo_data[0 +: 16];
   wire signed [7:0] k_sel = (f_phase == 2'h0) ? coef_r : (f_phase == 2'h1) ? coef_s
      : (f_phase == 2'h2) ? coef_t : 8'sh00;

   // products keep their full width; only the shifted difference is cut to
   // the 16 bits of the output, wrapping like the arithmetic it models
   // RULE3 voltage minus scaled integrated vector
   wire signed [23:0] volt_prod = k_sel * f_integ;
   wire signed [23:0] volt_diff = 24'(f_volt) - (volt_prod >>> pmcc_pkg::VOLT_SHIFT);
   // the shared sign bit of byte a negates both factors; the products are
   // scaled down by 8192 with an arithmetic shift
   // RULE10 RULE11 signed alpha and beta over 8192
   wire sign_ab = mutual_comp_byte_a[pmcc_pkg::SIGN_BIT];
   wire signed [9:0] alpha = sign_ab ? -$signed({2'b00, mutual_comp_byte_a[7:0]})
      : $signed({2'b00, mutual_comp_byte_a[7:0]});
   wire signed [9:0] beta = sign_ab ? -$signed({2'b00, mutual_comp_byte_b})
      : $signed({2'b00, mutual_comp_byte_b});
   wire signed [25:0] s_prod = beta * f_cur_t;
   wire signed [25:0] t_prod = alpha * f_cur_s;
   wire signed [25:0] s_diff = 26'(f_cur_s) - (s_prod >>> pmcc_pkg::MUT_SHIFT);
   wire signed [25:0] t_diff = 26'(f_cur_t) - (t_prod >>> pmcc_pkg::MUT_SHIFT);

   // voltage and currents of one word are registered on the same edge, so
   // the block adds no skew between the channels
   // RULE1 output stage, all channels in one cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_phase <= 2'h0;
         out_volt <= 16'h0000;
         out_cur_s <= 16'h0000;
         out_cur_t <= 16'h0000;
      end else begin
         out_valid <= pop;
         out_phase <= pop ? f_phase : out_phase;
         out_volt <= pop ? volt_diff[15:0] : out_volt;
         // RULE8 pass currents unchanged when correction is off
         out_cur_s <= pop ? (mutual_active ? s_diff[15:0] : f_cur_s) : out_cur_s;
         out_cur_t <= pop ? (mutual_active ? t_diff[15:0] : f_cur_t) : out_cur_t;
      end
   end

   // checks
   // all checks run on the block clock and are off while reset is low
   // tick spacing checks need the mode settled in the cycle before the tick
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   a_ack_next_cycle: assert property (bus_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   // RULE7 divide by two spacing
   a_tick_div_two: assert property ((precision_mode && !clock_divider_select) ##1 phc_tick
      |=> !phc_tick ##1 phc_tick) // RULE7
      else $error("tick spacing wrong for divide by two");
   // RULE8 sensor bit disables correction
   a_mutual_sensor_off: assert property (current_sensor_select |=> !mutual_active) // RULE8
      else $error("mutual correction active with sensor bit set");
   // RULE9 precision mode disables correction
   a_mutual_pm_off: assert property (precision_mode |=> !mutual_active) // RULE9
      else $error("mutual correction active in precision mode");
   // RULE4 positive branch range
   a_coef_base_pos: assert property ((!ext_mode && phase_coarse_trim[1]) |=> (coef_r >= 8'sh01 && coef_r <= 8'sh10)) // RULE4
      else $error("base positive coefficient out of range");
   // RULE5 negative extended branch
   a_coef_ext_neg: assert property ((ext_mode && !phase_coarse_trim[1]) |=> (coef_s <= 8'sh00 && coef_s >= -8'sh7F)) // RULE5
      else $error("extended negative coefficient out of range");
   // RULE6 extension bits scale by 32
   a_coef_ext_bits: assert property ((ext_mode && phase_coarse_trim == 2'b00 && phase_trim_t == 4'h0
      && phase_ext_trim == 2'b11) |=> coef_t == -8'sh60) // RULE6
      else $error("extension bits not taken from byte a");
   // RULE11 currents pass through when inactive
   a_cur_passthru: assert property ((pop && !mutual_active) |=> (out_cur_s == $past(f_cur_s)
      && out_cur_t == $past(f_cur_t))) // RULE11
      else $error("currents altered while correction inactive");

   c_fifo_full: cover property (!in_ready && in_valid);
   c_mutual_sample: cover property (out_valid && mutual_active);
   c_reg_write: cover property (bus_wr && sel_trim);
   // fast tick in precision mode
   c_tick_fast: cover property (precision_mode && phc_tick);
   // all extension bits in use
   c_ext_full: cover property (ext_mode && phase_ext_trim == 2'b11);

   // RULE7 tick is a single cycle pulse
   a_tick_one_cycle: assert property (phc_tick |=> !phc_tick) // RULE7
      else $error("tick longer than one cycle");

   // RULE7 divide by eight spacing
   a_tick_div_eight: assert property ((!precision_mode && !fast_clock_select) ##1 phc_tick
      |=> !phc_tick [*7] ##1 phc_tick) // RULE7
      else $error("tick spacing wrong for divide by eight");

   // RULE7 divide by four spacing
   a_tick_div_four: assert property ((!precision_mode && fast_clock_select) ##1 phc_tick
      |=> !phc_tick [*3] ##1 phc_tick) // RULE7
      else $error("tick spacing wrong for divide by four");

   // RULE3 output only after a tick pop
   a_out_after_tick: assert property (out_valid |-> $past(phc_tick)) // RULE3
      else $error("output word without a compensation tick");

   // RULE10 multi-phase topology disables correction
   a_mutual_topo_off: assert property ((line_topology <= pmcc_pkg::TOPO_MULTI_MAX) |=> !mutual_active) // RULE10
      else $error("mutual correction active for multi-phase topology");

   // RULE8 correction on when all conditions hold
   a_mutual_enable: assert property ((!current_sensor_select && !precision_mode
      && line_topology > pmcc_pkg::TOPO_MULTI_MAX) |=> mutual_active) // RULE8
      else $error("mutual correction not enabled");
endmodule // pmcc_top

// *** tb_top.sv ***
// self-checking testbench for the compensation block
`timescale 1ns/100ps
module tb_top;
   logic ref_clk, rst_n, cyc, stb, we, ack, iv, ir, ov, tick;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, dato, rd;
   logic [1:0] ip, op;
   logic [15:0] vi, gi, si, ti, vo, so, to;
   logic [49:0] seen[$];
   int errors = 0;
   int compares = 0;
   pmcc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
      .in_valid(iv), .in_ready(ir), .in_phase(ip), .in_volt(vi), .in_integ(gi), .in_cur_s(si),
      .in_cur_t(ti), .out_valid(ov), .out_phase(op), .out_volt(vo), .out_cur_s(so),
      .out_cur_t(to), .phc_tick(tick));
   pmcc_src_model src (.ref_clk(ref_clk), .in_ready(ir), .in_valid(iv), .in_phase(ip),
      .in_volt(vi), .in_integ(gi), .in_cur_s(si), .in_cur_t(ti));
   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // collect each word as it leaves
   always @(posedge ref_clk) begin
      if (ov === 1'b1) begin
         seen.push_back({op, vo, so, to});
      end
   end
   // verdict and end of run
   task automatic give_verdict;
      if (errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one classic bus cycle, started just after an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = dato;
      chk("wb_ack", 1, ack);
      if (ack !== 1'b1) give_verdict();
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
   endtask
   // expected coefficient
   function automatic int kc(logic [3:0] f, logic [1:0] c, logic [1:0] e, logic wide);
      int s;
      s = wide ? 32 * e + 16 * c[0] + f : 16 * c[0] + f;
      if (c[1]) return wide ? 64 - s : 16 - f;
      return -s;
   endfunction
   // expected compensated word
   function automatic logic [49:0] ew(logic [65:0] w, logic [31:0] ct, logic [31:0] tr, logic [31:0] mu);
      int k, al, be, v, s, t, os, ot;
      logic [1:0] p;
      p = w[65:64];
      k = (p == 2'h3) ? 0 : kc(tr[4 * p +: 4], ct[5:4], mu[1:0], ct[0] | ct[1]);
      al = mu[8] ? -int'(mu[7:0]) : int'(mu[7:0]);
      be = mu[8] ? -int'(mu[23:16]) : int'(mu[23:16]);
      s = int'($signed(w[31:16]));
      t = int'($signed(w[15:0]));
      v = int'($signed(w[63:48])) - ((k * int'($signed(w[47:32]))) >>> 6);
      os = s;
      ot = t;
      if (!ct[0] && !ct[1] && ct[10:8] > 3'h3) begin
         os = s - ((be * t) >>> 13);
         ot = t - ((al * s) >>> 13);
      end
      return {p, v[15:0], os[15:0], ot[15:0]};
   endfunction
   // reset values, read-only and unmapped places
   task automatic t_regs;
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk("reg_reset", 0, rd);
      end
      wb(1'b1, pmcc_pkg::ADDR_COEF, 32'hFFFF_FFFF);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, pmcc_pkg::ADDR_COEF, 32'h0);
      chk("coef_ro", 0, rd);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 0, rd);
   endtask
   // every coarse value in base, precision and sensor modes
   task automatic t_coef;
      logic [31:0] ct;
      wb(1'b1, pmcc_pkg::ADDR_TRIM, 32'h0000_0F93);
      wb(1'b1, pmcc_pkg::ADDR_MUTUAL, 32'h0000_0002);
      for (int i = 0; i < 12; i++) begin
         ct = 32'((i % 4) * 16 + (i / 4 == 1 ? 1 : 0) + (i / 4 == 2 ? 2 : 0));
         wb(1'b1, pmcc_pkg::ADDR_CTRL, ct);
         wb(1'b0, pmcc_pkg::ADDR_COEF, 32'h0);
         chk("coef", {8'h0, 8'(kc(4'hF, ct[5:4], 2'h2, ct[0] | ct[1])), 8'(kc(4'h9, ct[5:4], 2'h2,
            ct[0] | ct[1])), 8'(kc(4'h3, ct[5:4], 2'h2, ct[0] | ct[1]))}, rd);
      end
      wb(1'b1, pmcc_pkg::ADDR_TRIM, 32'h0000_0093);
      wb(1'b1, pmcc_pkg::ADDR_MUTUAL, 32'h0000_0003);
      wb(1'b1, pmcc_pkg::ADDR_CTRL, 32'h0000_0001);
      wb(1'b0, pmcc_pkg::ADDR_COEF, 32'h0);
      chk("coef_ext", 8'hA0, rd[23:16]);
   endtask
   // cycles to the next tick
   task automatic tk(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (tick !== 1'b1 && n < 20);
   endtask
   // tick period for each divider setting
   task automatic t_tick;
      logic [3:0] cv [6] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9};
      int pv [6] = '{8, 4, 8, 2, 2, 4};
      int n;
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, pmcc_pkg::ADDR_CTRL, {28'h0, cv[i]});
         repeat (2) tk(n);
         tk(n);
         chk("tick_period", pv[i], n);
      end
   endtask
   // send words, wait for them, compare
   task automatic burst(input logic [31:0] ct, input int cnt, input int gap);
      logic [65:0] w [$];
      int n, st;
      st = 0;
      seen.delete();
      for (int i = 0; i < cnt; i++) begin
         w.push_back({i[1:0], 16'(4096 + i * 273), 16'(-4096 + i * 77), 16'(8192 - i * 97), 16'(2048 + i * 53)});
         src.send(w[i], gap, gap > 0 || i == cnt - 1, n);
         st += (n > 1) ? 1 : 0;
         chk("in_taken", 1, n < 400);
      end
      for (n = 0; n < 400 && seen.size() < cnt; n++) @(posedge ref_clk);
      chk("out_count", cnt, seen.size());
      for (int i = 0; i < cnt; i++) chk("out_word", ew(w[i], ct, 32'h321, 32'h0020_0140), seen[i]);
      if (cnt > 16) chk("fifo_refused", 1, st > 0);
      chk("in_ready_drained", 1, ir);
   endtask
   // correction on, then each condition that turns it off
   task automatic t_stream;
      logic [31:0] cv [4] = '{32'h510, 32'h512, 32'h511, 32'h310};
      wb(1'b1, pmcc_pkg::ADDR_TRIM, 32'h321);
      wb(1'b1, pmcc_pkg::ADDR_MUTUAL, 32'h0020_0140);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, pmcc_pkg::ADDR_CTRL, cv[i]);
         wb(1'b0, pmcc_pkg::ADDR_COEF, 32'h0);
         chk("corr_active", i == 0, rd[31]);
         burst(cv[i], i == 0 ? 24 : 4, i == 0 ? 0 : 3);
      end
   endtask
   // main sequence
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, adr, dat} = '0;
      sel = 4'hF;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_coef();
      t_tick();
      t_stream();
      give_verdict();
   end
endmodule // tb_top
